//--- common/atc_map.svh
// opcodes, field positions, reset values and rate counts of the terminal control bank
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// serial instruction opcodes
`define ATC_OP_MASTER_RESET 8'h01
`define ATC_OP_ACLK_DIV_WR 8'h07
`define ATC_OP_STATUS_RD 8'h0A
`define ATC_OP_CFG_RD 8'h0B
`define ATC_OP_ACLK_DIV_RD 8'h0C
`define ATC_OP_CFG_WR 8'h10
`define ATC_OP_TX_FIFO_RESET 8'h11
`define ATC_OP_TX_START 8'h12

// serial bit counts at which opcode and data fields complete
`define ATC_BITS_OPCODE 5'h08
`define ATC_BITS_BYTE 5'h10
`define ATC_BITS_HALFWORD 5'h18
`define ATC_BITS_MAX 5'h1F

// reset values
`define ATC_CFG_RESET 16'h0000
`define ATC_DIV_RESET 8'h00

// device_configuration field positions
`define ATC_CFG_RX_RATE_SELECT 0
`define ATC_CFG_ARINC_CLOCK_SOURCE_SELECT 1
`define ATC_CFG_LABEL_FILTER_ENABLE 2
`define ATC_CFG_TX_PARITY_ENABLE 3
`define ATC_CFG_RX_PARITY_CHECK_ENABLE 4
`define ATC_CFG_SELF_TEST_N 5
`define ATC_CFG_RX_DECODER_ENABLE 6
`define ATC_CFG_DECODER_MATCH_BIT10 7
`define ATC_CFG_DECODER_MATCH_BIT9 8
`define ATC_CFG_TX_PARITY_SENSE 9
`define ATC_CFG_TX_RATE_SELECT 10
`define ATC_CFG_LABEL_ORDER_SELECT 11
`define ATC_CFG_LINE_DRIVER_DISABLE 12
`define ATC_CFG_TX_AUTO_MODE 13
`define ATC_CFG_TX_FLAG_SELECT 14
`define ATC_CFG_RX_FLAG_SELECT 15

// fifo_status field positions
`define ATC_ST_RX_FIFO_EMPTY 0
`define ATC_ST_RX_FIFO_HALF 1
`define ATC_ST_RX_FIFO_FULL 2
`define ATC_ST_TX_FIFO_EMPTY 3
`define ATC_ST_TX_FIFO_HALF 4
`define ATC_ST_TX_FIFO_FULL 5

// arinc word bit indices (index 0 is arinc bit 1)
`define ATC_ARINC_BIT9 8
`define ATC_ARINC_BIT10 9
`define ATC_ARINC_PARITY 31

// rate divisions and allowed aux clock divisors
`define ATC_RATE_FAST 8'h0A
`define ATC_RATE_SLOW 8'h50
`define ATC_DIV_X1 8'h01
`define ATC_DIV_X2 8'h02
`define ATC_DIV_X4 8'h04
`define ATC_DIV_X8 8'h08
`define ATC_DIV_XA 8'h0A

// fifo geometry
`define ATC_FIFO_DEPTH 32
`define ATC_HALF_WORDS 16

`endif

//--- common/atc_pkg.sv
// types shared by the terminal control bank
package atc_pkg;

	// serial transaction phase, one-hot
	typedef enum logic [2:0] {
		ATC_PH_IDLE = 3'b001,
		ATC_PH_OPCODE = 3'b010,
		ATC_PH_DATA = 3'b100
	} atc_phase_t;

	// complete state of the control bank
	typedef struct packed {
		atc_phase_t phase;
		logic sckPrev;
		logic [4:0] bitCnt;
		logic [7:0] opcode;
		logic [15:0] shiftIn;
		logic [15:0] shiftOut;
		logic [15:0] cfgWord;
		logic [7:0] aclkDivisor;
		logic [7:0] status;
		logic rxFlag;
		logic txFlag;
		logic txRun;
		logic arincTick;
		logic rxFifoClear;
		logic txFifoClear;
		logic rxLoad;
		logic [31:0] rxLoadWord;
		logic [31:0] txWordOut;
		logic rxInOne;
		logic rxInZero;
		logic txLineOne;
		logic txLineZero;
	} atc_state_t;

endpackage

//--- logic/atc_tick_divider.sv
// enable-pulse divider: one output pulse per divisor input pulses
`timescale 1ns/1ps
module atc_tick_divider #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic tickIn,
	input wire logic [WIDTH-1:0] divisor,
	output logic tickOut
);
	import atc_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic tick;
	} atc_div_state_t;

	atc_div_state_t st_reg;
	atc_div_state_t st_next;

	if (WIDTH < 4) begin : g_width_check
		$error("atc_tick_divider: WIDTH must be at least 4");
	end

	// a zero divisor stops the output, which is how an illegal clock divisor shows
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (divisor == '0) begin
			st_next.count = '0;
		end else if (tickIn) begin
			if (st_reg.count >= divisor - 1'b1) begin
				st_next.count = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.count = st_reg.count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tickOut = st_reg.tick;

	property p_div_needs_input;
		@(posedge clk) disable iff (reset)
		tickOut |-> $past(tickIn) && ($past(divisor) != '0);
	endproperty
	a_div_needs_input: assert property (p_div_needs_input)
		else $error("divider pulsed without an input tick or with zero divisor");

endmodule

//--- logic/atc_ctrl_status_regs.sv
// control and status register bank of the arinc terminal, reached over the serial port
// Function
// - config write opcode loads sixteen bits MSB first
// - config read opcode returns config unchanged
// - rx rate bit picks clock/10 or clock/80
// - clock source bit picks aux or divided aux
// - tx parity enable makes bit 32 parity
// - rx parity check bit enables odd check
// - self-test low loops transmitter into receiver
// - decoder enable compares bits 10 and 9
// - tx parity sense picks odd or even
// - tx rate bit picks rate and slope
// - label order bit reverses or keeps label
// - driver disable forces transmit outputs null
// - manual mode needs start opcode, auto sends
// - tx flag shows empty or full
// - rx flag shows empty or full
// - status read shifts byte, top bits zero
// - rx empty low while rx data held
// - rx half set at sixteen words or more
// - rx full set when receive fifo full
// - tx empty low while words remain unsent
// - tx half at sixteen, full at thirty-two
// - each flag pin mirrors its chosen bit
// - receive word stored only passing enabled filters
`timescale 1ns/1ps
`include "atc_map.svh"
module atc_ctrl_status_regs #(
	parameter int FIFO_DEPTH = `ATC_FIFO_DEPTH,
	parameter int HALF_WORDS = `ATC_HALF_WORDS,
	parameter int CW = $clog2(FIFO_DEPTH + 1)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic masterReset,
	input wire logic spiSck,
	input wire logic spiCsN,
	input wire logic spiSi,
	output logic spiSo,
	input wire logic aclkTick,
	output logic arincTick,
	output logic rxBitTick,
	output logic txBitTick,
	input wire logic [CW-1:0] rxFifoCount,
	input wire logic [CW-1:0] txFifoCount,
	input wire logic rxWordValid,
	input wire logic [31:0] rxWord,
	input wire logic rxLabelEnabled,
	output logic rxLoad,
	output logic [31:0] rxLoadWord,
	input wire logic [31:0] txWordIn,
	output logic [31:0] txWordOut,
	input wire logic lineRxOne,
	input wire logic lineRxZero,
	input wire logic txDigOne,
	input wire logic txDigZero,
	output logic rxInOne,
	output logic rxInZero,
	output logic txLineOne,
	output logic txLineZero,
	output logic txSlowSlope,
	output logic txRun,
	output logic rxFifoClear,
	output logic txFifoClear,
	output logic [15:0] devConfig,
	output logic [7:0] fifoStatus,
	output logic rxFlagPin,
	output logic txFlagPin
);
	import atc_pkg::*;

	atc_pkg::atc_state_t st_reg;
	atc_pkg::atc_state_t st_next;

	logic [7:0] arincDivisor;
	logic [7:0] rxRateDivisor;
	logic [7:0] txRateDivisor;
	logic divTick;
	logic sckRise;
	logic sckFall;
	logic [15:0] shiftInNext;
	logic cfgWrHit;
	logic readLoadHit;
	logic [15:0] readValue;

	if (FIFO_DEPTH < 2 * HALF_WORDS || FIFO_DEPTH < 2) begin : g_depth_check
		$error("atc_ctrl_status_regs: FIFO_DEPTH must hold at least two half loads");
	end

	// label is arinc bits 1..8; the involution serves both directions
	function automatic logic [31:0] map_label(input logic [31:0] word, input logic keepOrder);
		logic [31:0] res;
		res = word;
		if (!keepOrder) begin
			for (int i = 0; i < 8; i++) begin
				res[i] = word[7 - i];
			end
		end
		return res;
	endfunction

	// only the listed aux clock divisors give a clock; any other value stops it
	always_comb begin
		case (st_reg.aclkDivisor)
			`ATC_DIV_X1, `ATC_DIV_X2, `ATC_DIV_X4, `ATC_DIV_X8, `ATC_DIV_XA: begin
				arincDivisor = st_reg.aclkDivisor;
			end
			default: begin
				arincDivisor = 8'h00;
			end
		endcase
	end

	// bit rate divisions for each direction
	assign rxRateDivisor = st_reg.cfgWord[`ATC_CFG_RX_RATE_SELECT] ? `ATC_RATE_SLOW
		: `ATC_RATE_FAST;
	assign txRateDivisor = st_reg.cfgWord[`ATC_CFG_TX_RATE_SELECT] ? `ATC_RATE_SLOW
		: `ATC_RATE_FAST;

	atc_tick_divider #(.WIDTH(8)) u_aclk_div (
		.clk(clk),
		.reset(reset),
		.tickIn(aclkTick),
		.divisor(arincDivisor),
		.tickOut(divTick)
	);

	atc_tick_divider #(.WIDTH(8)) u_rx_rate (
		.clk(clk),
		.reset(reset),
		.tickIn(st_reg.arincTick),
		.divisor(rxRateDivisor),
		.tickOut(rxBitTick)
	);

	atc_tick_divider #(.WIDTH(8)) u_tx_rate (
		.clk(clk),
		.reset(reset),
		.tickIn(st_reg.arincTick),
		.divisor(txRateDivisor),
		.tickOut(txBitTick)
	);

	// serial clock is taken as synchronous, so edges come from one registered copy
	assign sckRise = !spiCsN && spiSck && !st_reg.sckPrev;
	assign sckFall = !spiCsN && !spiSck && st_reg.sckPrev;
	assign shiftInNext = {st_reg.shiftIn[14:0], spiSi};
	assign cfgWrHit = sckRise && st_reg.phase == ATC_PH_DATA
		&& st_reg.opcode == `ATC_OP_CFG_WR
		&& st_reg.bitCnt == `ATC_BITS_HALFWORD - 5'h01;
	assign readLoadHit = sckFall && st_reg.phase == ATC_PH_DATA
		&& st_reg.bitCnt == `ATC_BITS_OPCODE;

	// read data is left aligned so byte reads leave MSB first too
	always_comb begin
		case (st_reg.opcode)
			`ATC_OP_STATUS_RD: readValue = {st_reg.status, 8'h00};
			`ATC_OP_CFG_RD: readValue = st_reg.cfgWord;
			`ATC_OP_ACLK_DIV_RD: readValue = {st_reg.aclkDivisor, 8'h00};
			default: readValue = 16'h0000;
		endcase
	end

	// next state of the whole bank
	always_comb begin
		logic rxEmpty;
		logic rxHalf;
		logic rxFull;
		logic txEmpty;
		logic txHalf;
		logic txFull;
		logic accept;
		logic [31:0] rxMapped;
		logic [31:0] txMapped;
		logic txPar;
		logic startCmd;
		rxEmpty = 1'b1;
		rxHalf = 1'b0;
		rxFull = 1'b0;
		txEmpty = 1'b1;
		txHalf = 1'b0;
		txFull = 1'b0;
		accept = 1'b0;
		rxMapped = 32'h0000_0000;
		txMapped = 32'h0000_0000;
		txPar = 1'b0;
		startCmd = 1'b0;
		st_next = st_reg;
		st_next.sckPrev = spiSck;
		st_next.rxFifoClear = 1'b0;
		st_next.txFifoClear = 1'b0;
		st_next.rxLoad = 1'b0;

		// serial transaction: opcode, then write data in or read data out
		if (spiCsN) begin
			st_next.phase = ATC_PH_IDLE;
			st_next.bitCnt = 5'h00;
			st_next.shiftOut = 16'h0000;
		end else begin
			if (st_reg.phase == ATC_PH_IDLE) begin
				st_next.phase = ATC_PH_OPCODE;
			end
			if (sckRise) begin
				st_next.shiftIn = shiftInNext;
				if (st_reg.bitCnt != `ATC_BITS_MAX) begin
					st_next.bitCnt = st_reg.bitCnt + 5'h01;
				end
				if (st_reg.bitCnt == `ATC_BITS_OPCODE - 5'h01) begin
					st_next.opcode = shiftInNext[7:0];
					st_next.phase = ATC_PH_DATA;
					case (shiftInNext[7:0])
						`ATC_OP_MASTER_RESET: begin
							st_next.rxFifoClear = 1'b1;
							st_next.txFifoClear = 1'b1;
						end
						`ATC_OP_TX_FIFO_RESET: st_next.txFifoClear = 1'b1;
						`ATC_OP_TX_START: startCmd = 1'b1;
						default: startCmd = 1'b0;
					endcase
				end
				if (st_reg.phase == ATC_PH_DATA && st_reg.opcode == `ATC_OP_ACLK_DIV_WR
					&& st_reg.bitCnt == `ATC_BITS_BYTE - 5'h01) begin
					st_next.aclkDivisor = shiftInNext[7:0];
				end
				if (cfgWrHit) begin
					st_next.cfgWord = shiftInNext;
				end
			end
			// the host samples on the rising edge, so data moves on the falling one
			if (readLoadHit) begin
				st_next.shiftOut = readValue;
			end else if (sckFall && st_reg.phase == ATC_PH_DATA) begin
				st_next.shiftOut = {st_reg.shiftOut[14:0], 1'b0};
			end
		end

		// master reset pin also clears both fifos
		if (masterReset) begin
			st_next.rxFifoClear = 1'b1;
			st_next.txFifoClear = 1'b1;
		end

		// fifo indications, forced to empty while the master reset pin is high
		if (!masterReset) begin
			rxEmpty = rxFifoCount == '0;
			rxHalf = rxFifoCount >= CW'(HALF_WORDS);
			rxFull = rxFifoCount >= CW'(FIFO_DEPTH);
			txEmpty = txFifoCount == '0;
			txHalf = txFifoCount >= CW'(HALF_WORDS);
			txFull = txFifoCount >= CW'(FIFO_DEPTH);
		end
		st_next.status = {2'b00, txFull, txHalf, txEmpty, rxFull, rxHalf, rxEmpty};
		st_next.rxFlag = st_reg.cfgWord[`ATC_CFG_RX_FLAG_SELECT] ? rxFull : rxEmpty;
		st_next.txFlag = st_reg.cfgWord[`ATC_CFG_TX_FLAG_SELECT] ? txFull : txEmpty;

		// transmission start: set wins over the empty clear in manual mode
		if (st_reg.cfgWord[`ATC_CFG_TX_AUTO_MODE]) begin
			st_next.txRun = !txEmpty;
		end else if (startCmd) begin
			st_next.txRun = 1'b1;
		end else if (txEmpty || st_next.txFifoClear) begin
			st_next.txRun = 1'b0;
		end

		// arinc clock source
		st_next.arincTick = st_reg.cfgWord[`ATC_CFG_ARINC_CLOCK_SOURCE_SELECT] ? divTick
			: aclkTick;

		// receive filters, label mapping and parity
		accept = (!st_reg.cfgWord[`ATC_CFG_LABEL_FILTER_ENABLE] || rxLabelEnabled)
			&& (!st_reg.cfgWord[`ATC_CFG_RX_DECODER_ENABLE]
			|| (rxWord[`ATC_ARINC_BIT10] == st_reg.cfgWord[`ATC_CFG_DECODER_MATCH_BIT10]
			&& rxWord[`ATC_ARINC_BIT9] == st_reg.cfgWord[`ATC_CFG_DECODER_MATCH_BIT9]));
		rxMapped = map_label(rxWord, st_reg.cfgWord[`ATC_CFG_LABEL_ORDER_SELECT]);
		if (st_reg.cfgWord[`ATC_CFG_RX_PARITY_CHECK_ENABLE]) begin
			rxMapped[`ATC_ARINC_PARITY] = !(^rxWord);
		end
		if (rxWordValid && accept) begin
			st_next.rxLoad = 1'b1;
			st_next.rxLoadWord = rxMapped;
		end

		// transmit word: label mapping and generated parity
		txMapped = map_label(txWordIn, st_reg.cfgWord[`ATC_CFG_LABEL_ORDER_SELECT]);
		txPar = ^txMapped[30:0];
		if (st_reg.cfgWord[`ATC_CFG_TX_PARITY_ENABLE]) begin
			txMapped[`ATC_ARINC_PARITY] = st_reg.cfgWord[`ATC_CFG_TX_PARITY_SENSE] ? txPar
				: !txPar;
		end
		st_next.txWordOut = txMapped;

		// self-test loopback takes the digital outputs ahead of the driver disable
		st_next.rxInOne = st_reg.cfgWord[`ATC_CFG_SELF_TEST_N] ? lineRxOne : txDigOne;
		st_next.rxInZero = st_reg.cfgWord[`ATC_CFG_SELF_TEST_N] ? lineRxZero : txDigZero;
		st_next.txLineOne = !st_reg.cfgWord[`ATC_CFG_LINE_DRIVER_DISABLE] && txDigOne;
		st_next.txLineZero = !st_reg.cfgWord[`ATC_CFG_LINE_DRIVER_DISABLE] && txDigZero;
	end

	// single register stage for all bank state
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.phase <= ATC_PH_IDLE;
			st_reg.cfgWord <= `ATC_CFG_RESET;
			st_reg.aclkDivisor <= `ATC_DIV_RESET;
			st_reg.status <= 8'h09;
			st_reg.rxFlag <= 1'b1;
			st_reg.txFlag <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign spiSo = st_reg.shiftOut[15];
	assign arincTick = st_reg.arincTick;
	assign rxLoad = st_reg.rxLoad;
	assign rxLoadWord = st_reg.rxLoadWord;
	assign txWordOut = st_reg.txWordOut;
	assign rxInOne = st_reg.rxInOne;
	assign rxInZero = st_reg.rxInZero;
	assign txLineOne = st_reg.txLineOne;
	assign txLineZero = st_reg.txLineZero;
	assign txSlowSlope = st_reg.cfgWord[`ATC_CFG_TX_RATE_SELECT];
	assign txRun = st_reg.txRun;
	assign rxFifoClear = st_reg.rxFifoClear;
	assign txFifoClear = st_reg.txFifoClear;
	assign devConfig = st_reg.cfgWord;
	assign fifoStatus = st_reg.status;
	assign rxFlagPin = st_reg.rxFlag;
	assign txFlagPin = st_reg.txFlag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_cfg_write;
		cfgWrHit |=> st_reg.cfgWord == $past(shiftInNext);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("config write did not load the shifted word");

	property p_cfg_hold;
		!cfgWrHit |=> $stable(st_reg.cfgWord);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("config changed without a config write");

	property p_cfg_read;
		readLoadHit && st_reg.opcode == `ATC_OP_CFG_RD |=> spiSo == $past(st_reg.cfgWord[15]);
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("config read did not present the config MSB");

	property p_status_top;
		fifoStatus[7:6] == 2'b00;
	endproperty
	a_status_top: assert property (p_status_top)
		else $error("unused status bits not zero");

	property p_rx_half;
		!masterReset |=> fifoStatus[`ATC_ST_RX_FIFO_HALF] == ($past(rxFifoCount) >= CW'(HALF_WORDS));
	endproperty
	a_rx_half: assert property (p_rx_half)
		else $error("rx half flag disagrees with fifo count");

	property p_tx_empty;
		!masterReset |=> fifoStatus[`ATC_ST_TX_FIFO_EMPTY] == ($past(txFifoCount) == '0);
	endproperty
	a_tx_empty: assert property (p_tx_empty)
		else $error("tx empty flag disagrees with fifo count");

	property p_rx_flag;
		##1 rxFlagPin == ($past(st_reg.cfgWord[`ATC_CFG_RX_FLAG_SELECT])
			? fifoStatus[`ATC_ST_RX_FIFO_FULL] : fifoStatus[`ATC_ST_RX_FIFO_EMPTY]);
	endproperty
	a_rx_flag: assert property (p_rx_flag)
		else $error("rx flag pin does not mirror its status bit");

	property p_tx_parity;
		st_reg.cfgWord[`ATC_CFG_TX_PARITY_ENABLE]
			|=> (^txWordOut) == !$past(st_reg.cfgWord[`ATC_CFG_TX_PARITY_SENSE]);
	endproperty
	a_tx_parity: assert property (p_tx_parity)
		else $error("transmit parity has the wrong sense");

	property p_loopback;
		!st_reg.cfgWord[`ATC_CFG_SELF_TEST_N] |=> rxInOne == $past(txDigOne)
			&& rxInZero == $past(txDigZero);
	endproperty
	a_loopback: assert property (p_loopback)
		else $error("self test did not loop transmitter into receiver");

	property p_driver_null;
		st_reg.cfgWord[`ATC_CFG_LINE_DRIVER_DISABLE] |=> !txLineOne && !txLineZero;
	endproperty
	a_driver_null: assert property (p_driver_null)
		else $error("disabled driver left the line out of null");

	property p_decoder_reject;
		rxWordValid && st_reg.cfgWord[`ATC_CFG_RX_DECODER_ENABLE]
			&& rxWord[`ATC_ARINC_BIT9] != st_reg.cfgWord[`ATC_CFG_DECODER_MATCH_BIT9] |=> !rxLoad;
	endproperty
	a_decoder_reject: assert property (p_decoder_reject)
		else $error("word with mismatched bit 9 was stored");

	property p_tx_auto;
		!masterReset && st_reg.cfgWord[`ATC_CFG_TX_AUTO_MODE] && txFifoCount != '0 |=> txRun;
	endproperty
	a_tx_auto: assert property (p_tx_auto)
		else $error("auto mode did not transmit pending data");

	c_cfg_write: cover property (cfgWrHit);
	c_status_read: cover property (readLoadHit && st_reg.opcode == `ATC_OP_STATUS_RD);
	c_rx_load: cover property (rxLoad ##1 !rxLoad);
	c_tx_start: cover property (!st_reg.cfgWord[`ATC_CFG_TX_AUTO_MODE] && $rose(txRun));

endmodule

//--- verification/atc_spi_host.sv
// serial host model for the terminal's four-wire port, clock idle low
`timescale 1ns/1ps
module atc_spi_host (
	input wire logic clk,
	output logic spiSck,
	output logic spiCsN,
	output logic spiSi,
	input wire logic spiSo
);
	// idle: deselected, clock low, data line at its pull-down level
	initial begin
		spiSck = 1'b0;
		spiCsN = 1'b1;
		spiSi = 1'b0;
	end

	// one framed command; each sck phase spans two clk so the device samples every edge
	task automatic xfer(input logic [7:0] op, input logic [15:0] wd, input int n,
		output logic [15:0] rd);
		logic [23:0] sh;
		sh = {op, wd};
		rd = 16'h0000;
		@(negedge clk);
		spiCsN = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			spiSi = sh[23 - i];
			repeat (2) @(negedge clk);
			spiSck = 1'b1;
			if (i >= 8) begin
				rd = {rd[14:0], spiSo};
			end
			repeat (2) @(negedge clk);
			spiSck = 1'b0;
		end
		repeat (2) @(negedge clk);
		// deselect between commands restarts the device's bit count
		spiCsN = 1'b1;
		spiSi = 1'b0;
		repeat (2) @(negedge clk);
	endtask
endmodule

//--- verification/tb.sv
// self-checking bench for the terminal control and status bank
`timescale 1ns/1ps
`include "atc_map.svh"
module tb;
	logic clk, reset, masterReset, spiSck, spiCsN, spiSi, spiSo, aclkTick, arincTick;
	logic rxBitTick, txBitTick, rxWordValid, rxLabelEnabled, rxLoad, seen;
	logic [5:0] rxCnt, txCnt;
	logic [31:0] rxWord, rxLoadWord, txWordIn, txWordOut, w;
	logic lineRxOne, lineRxZero, txDigOne, txDigZero, rxInOne, rxInZero;
	logic txLineOne, txLineZero, txSlowSlope, txRun, rxFifoClear, txFifoClear;
	logic rxFlagPin, txFlagPin;
	logic [15:0] devConfig, rd, cfg;
	logic [7:0] fifoStatus;
	int badCount, comparisons, rxTicks, txTicks;
	int arTicks, rxClr, txClr, rxN, txN, arN;
	int lv[6] = '{0, 1, 15, 16, 31, 32};

	atc_ctrl_status_regs u_dut (.clk(clk), .reset(reset), .masterReset(masterReset),
		.spiSck(spiSck), .spiCsN(spiCsN), .spiSi(spiSi), .spiSo(spiSo),
		.aclkTick(aclkTick), .arincTick(arincTick), .rxBitTick(rxBitTick),
		.txBitTick(txBitTick), .rxFifoCount(rxCnt), .txFifoCount(txCnt),
		.rxWordValid(rxWordValid), .rxWord(rxWord), .rxLabelEnabled(rxLabelEnabled),
		.rxLoad(rxLoad), .rxLoadWord(rxLoadWord), .txWordIn(txWordIn),
		.txWordOut(txWordOut), .lineRxOne(lineRxOne), .lineRxZero(lineRxZero),
		.txDigOne(txDigOne), .txDigZero(txDigZero), .rxInOne(rxInOne),
		.rxInZero(rxInZero), .txLineOne(txLineOne), .txLineZero(txLineZero),
		.txSlowSlope(txSlowSlope), .txRun(txRun), .rxFifoClear(rxFifoClear),
		.txFifoClear(txFifoClear), .devConfig(devConfig), .fifoStatus(fifoStatus),
		.rxFlagPin(rxFlagPin), .txFlagPin(txFlagPin));
	atc_spi_host u_host (.clk(clk), .spiSck(spiSck), .spiCsN(spiCsN), .spiSi(spiSi),
		.spiSo(spiSo));

	// 40 MHz device clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// free-running pulse counters; the sequence takes differences so only this process writes them
	always @(posedge clk) begin
		rxTicks <= rxTicks + int'(rxBitTick);
		txTicks <= txTicks + int'(txBitTick);
		arTicks <= arTicks + int'(arincTick);
		rxClr <= rxClr + int'(rxFifoClear);
		txClr <= txClr + int'(txFifoClear);
	end

	task automatic testDone;
		if (badCount == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			badCount++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wcfg(input logic [15:0] v);
		u_host.xfer(`ATC_OP_CFG_WR, v, 16, rd);
	endtask

	// label field reversed unless the order bit keeps it
	function automatic logic [31:0] lab(input logic [31:0] x, input logic keep);
		lab = x;
		for (int i = 0; i < 8; i++) begin
			lab[i] = keep ? x[i] : x[7 - i];
		end
	endfunction

	function automatic logic [7:0] stat(input int r, input int t);
		stat = {2'b00, t >= 32, t >= 16, t == 0, r >= 32, r >= 16, r == 0};
	endfunction

	// hang guard, well beyond the expected run of about 7000 cycles
	initial begin
		#(25 * 60000);
		badCount++;
		testDone();
	end

	// main sequence
	initial begin
		{reset, aclkTick} = 2'b11;
		{masterReset, rxWordValid, rxLabelEnabled, lineRxOne, lineRxZero} = 5'h00;
		{txDigOne, txDigZero, rxCnt, txCnt} = 14'h0000;
		{rxWord, txWordIn} = 64'h0000_0000_0000_0000;
		badCount = 0;
		comparisons = 0;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		chk("fifoStatus", stat(0, 0), fifoStatus);
		chk("flags", 2'b11, {rxFlagPin, txFlagPin});
		wcfg(16'hA5C3);
		chk("devConfig", 16'hA5C3, devConfig);
		repeat (2) begin
			u_host.xfer(`ATC_OP_CFG_RD, 16'h0000, 16, rd);
			chk("cfgRead", 16'hA5C3, rd);
		end
		// occupancy table against both flag definitions
		for (int f = 0; f < 2; f++) begin
			wcfg({f[0], f[0], 14'h0000});
			foreach (lv[i]) begin
				rxCnt = 6'(lv[i]);
				txCnt = 6'(lv[5 - i]);
				repeat (2) @(negedge clk);
				chk("fifoStatus", stat(lv[i], lv[5 - i]), fifoStatus);
				chk("rxFlagPin", f ? lv[i] >= 32 : lv[i] == 0, rxFlagPin);
				chk("txFlagPin", f ? lv[5 - i] >= 32 : lv[5 - i] == 0, txFlagPin);
				u_host.xfer(`ATC_OP_STATUS_RD, 16'h0000, 8, rd);
				chk("statRead", stat(lv[i], lv[5 - i]), rd);
			end
		end
		// receive filters, parity check and label order; bits 10/9 must be 1/0
		for (int k = 0; k < 16; k++) begin
			cfg = 16'h0080 | 16'(k[0]) << 2 | 16'(k[0]) << 4 | 16'(k[1]) << 6 | 16'(k[1]) << 11;
			wcfg(cfg);
			rxWord = {22'h048D15, k[3] ? 2'b10 : 2'b01, 8'hA7};
			rxLabelEnabled = k[2];
			rxWordValid = 1'b1;
			@(negedge clk);
			rxWordValid = 1'b0;
			seen = rxLoad;
			@(negedge clk);
			seen = seen | rxLoad;
			chk("rxLoad", (!k[0] || k[2]) && (!k[1] || k[3]), seen);
			w = lab(rxWord, k[1]);
			if (k[0]) w[31] = ~^rxWord;
			if (seen === 1'b1) chk("rxLoadWord", w, rxLoadWord);
		end
		// loopback, driver disable, transmit parity and slope
		{lineRxOne, lineRxZero, txDigOne, txDigZero} = 4'b1001;
		txWordIn = 32'h8000_0013;
		for (int k = 0; k < 8; k++) begin
			wcfg(16'h0008 | 16'(k[0]) << 5 | 16'(k[1]) << 12 | 16'(k[2]) << 9 | 16'(k[2]) << 10
				| 16'(k[0]) << 11);
			chk("rxIn", k[0] ? 2'b10 : 2'b01, {rxInOne, rxInZero});
			chk("txLine", k[1] ? 2'b00 : 2'b01, {txLineOne, txLineZero});
			w = lab(txWordIn, k[0]);
			w[31] = ^w[30:0] ^ !k[2];
			chk("txWordOut", w, txWordOut);
			chk("txSlowSlope", k[2], txSlowSlope);
		end
		// bit rates over 800 aux ticks: /10 gives 80, /80 gives 10, divided aux by 2 gives 40
		u_host.xfer(`ATC_OP_ACLK_DIV_WR, {`ATC_DIV_X2, 8'h00}, 8, rd);
		u_host.xfer(`ATC_OP_ACLK_DIV_RD, 16'h0000, 8, rd);
		chk("divRead", `ATC_DIV_X2, rd);
		for (int k = 0; k < 3; k++) begin
			wcfg(k == 0 ? 16'h0001 : k == 1 ? 16'h0400 : 16'h0002);
			rxN = rxTicks;
			txN = txTicks;
			arN = arTicks;
			repeat (800) @(negedge clk);
			rxN = rxTicks - rxN;
			txN = txTicks - txN;
			arN = arTicks - arN;
			chk("rxTicks", 1, (rxN - (k == 0 ? 10 : k == 1 ? 80 : 40)) inside {[-1:1]});
			chk("txTicks", 1, (txN - (k == 0 ? 80 : k == 1 ? 10 : 40)) inside {[-1:1]});
			chk("arincTicks", 1, (arN - (k == 2 ? 400 : 800)) inside {[-1:1]});
		end
		// transmit start: automatic follows occupancy, manual waits for the start command
		wcfg(16'h2000);
		txCnt = 6'h03;
		repeat (3) @(negedge clk);
		chk("txRun", 1, txRun);
		txCnt = 6'h00;
		repeat (3) @(negedge clk);
		chk("txRun", 0, txRun);
		wcfg(16'h0000);
		txCnt = 6'h03;
		repeat (3) @(negedge clk);
		chk("txRun", 0, txRun);
		u_host.xfer(`ATC_OP_TX_START, 16'h0000, 0, rd);
		chk("txRun", 1, txRun);
		txCnt = 6'h00;
		repeat (3) @(negedge clk);
		chk("txRun", 0, txRun);
		// master reset pin forces empty for its cycle; pin and master reset opcode pulse both clears once, tx reset opcode the tx clear only
		rxCnt = 6'h05;
		txCnt = 6'h05;
		rxN = rxClr;
		txN = txClr;
		masterReset = 1'b1;
		@(negedge clk);
		chk("fifoStatus", 8'h09, fifoStatus);
		chk("flags", 2'b11, {rxFlagPin, txFlagPin});
		masterReset = 1'b0;
		@(negedge clk);
		chk("fifoStatus", stat(5, 5), fifoStatus);
		u_host.xfer(`ATC_OP_MASTER_RESET, 16'h0000, 0, rd);
		u_host.xfer(`ATC_OP_TX_FIFO_RESET, 16'h0000, 0, rd);
		chk("rxClear", 2, rxClr - rxN);
		chk("txClear", 3, txClr - txN);
		testDone();
	end
endmodule
